// ===== pkg/hop_tx_pkg.sv
// Constants, types and reset values of the hopping code word transmitter.
// Assumes a 200 MHz clock and a classic Wishbone master for the registers.
// What this block does
// RULE_01: Four trim bits scale every element length.
// RULE_02: Trip level from level select and force.
// RULE_03: Rate bit halves element, blanks alternate words.
// RULE_04: Min-count bit forces four complete words.
// RULE_05: Lead bit adds one-element start pulse.
// RULE_06: Force bit sets fourth function bit.
// RULE_07: Short serial: top nibble becomes function code.
// RULE_08: Preamble, header, hopping, fixed, then guard.
// RULE_09: Payload 66 bits: 32 hopping, 34 fixed.
// RULE_10: Plaintext is function, discrimination, sync counter.
// RULE_11: Fixed part: status, function, serial number.
// RULE_12: Clock-pin fall with a or b enters sync.
// RULE_13: Outside clock at most 20 kHz, waits.
// RULE_14: Sync mode appends 16 reserved zero bits.
// RULE_15: Mode test 25 us, pin output 90 later.
// RULE_16: Finish word, then stop if released.
// RULE_17: Held button repeats words back to back.
// RULE_18: New button aborts word, rebuilds code.
// RULE_19: All three buttons send the seed.
// RULE_20: Stop after continuous hold timeout.
// RULE_21: Boost pulses when low supply and transmitting.
// RULE_22: Battery flag sent when below trip point.
// RULE_23: Option bits at fixed configuration positions.
// RULE_24: Wait 4.5 ms debounce before sampling.
// RULE_25: Separate cipher module, framer waits done.
// RULE_26: Preamble, header, guard lengths are parameters.
// RULE_27: Bit is high, data-dependent, low elements.
package hop_tx_pkg;

	// Timebase
	localparam int CLK_MHZ = 200;
	localparam int TE_LONG_US = 400;
	localparam int TE_SHORT_US = 200;
	localparam int DEBOUNCE_US = 4500;
	localparam int MODE_TEST_US = 25;
	localparam int OE_DELAY_US = 90;
	localparam int SHUTOFF_MS = 20000;
	localparam int BOOST_KHZ = 100;
	localparam int BOOST_HALF_CYC = CLK_MHZ * 1000 / (2 * BOOST_KHZ);
	localparam int TRIM_MID = 8; // Trim code giving the nominal rate
	localparam int TRIM_SHIFT = 6; // One trim step is 1/64 of an element

	// Word layout
	localparam int HOP_BITS = 32;
	localparam int WORD_BITS = 66;
	localparam int SYNC_BITS = 82; // Word plus 16 reserved bits
	localparam int SER_LOW_BITS = 28;
	localparam int REPEAT_POS = 64;
	localparam int BATT_POS = 65;
	localparam int MIN_WORDS = 4;

	// Configuration word fields
	localparam int CFG_TRIM_LSB = 0;
	localparam int CFG_TRIM_MSB = 3;
	localparam int CFG_LEVEL = 4;
	localparam int CFG_RATE = 5;
	localparam int CFG_MIN = 6;
	localparam int CFG_LEAD = 7;
	localparam int CFG_FORCE = 8;
	localparam int CFG_FULL = 9;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_KEY_LO = 8'h04;
	localparam logic [7:0] OFS_KEY_HI = 8'h08;
	localparam logic [7:0] OFS_SYNC = 8'h0C;
	localparam logic [7:0] OFS_SERIAL = 8'h10;
	localparam logic [7:0] OFS_SEED = 8'h14;
	localparam logic [7:0] OFS_DISC = 8'h18;
	localparam logic [7:0] OFS_CONTROL = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;

	// Cipher
	localparam logic [9:0] CIPHER_ROUNDS = 10'h210;
	localparam logic [31:0] MIX_TABLE = 32'h3A5C_742E; // Arbitrary mixing

	typedef struct packed {
		logic c; // Third input, also the outside bit clock
		logic b;
		logic a;
	} btn_t;

	typedef struct packed {
		logic below_hi; // Below the 9 level
		logic below_mid; // Below the 6.75 level
		logic below_lo; // Below the 4.4 level
	} supply_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_DEBOUNCE = 4'h1,
		S_CIPHER = 4'h3,
		S_LEAD = 4'h2,
		S_PREAMBLE = 4'h6,
		S_HEADER = 4'h7,
		S_DATA = 4'h5,
		S_GUARD = 4'h4,
		S_SYNC_TEST = 4'hC,
		S_SYNC_SHIFT = 4'hD
	} state_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic [9:0] cnt;
		logic [31:0] data;
		logic [63:0] key;
	} cip_t;

	localparam cip_t CIP_RST = '0;

	typedef struct packed {
		state_t state;
		logic [31:0] tmr;
		logic [31:0] alive;
		logic [6:0] bit_idx;
		logic [1:0] phase;
		logic [6:0] te_left;
		logic [2:0] words;
		logic odd;
		logic first;
		logic shut;
		logic sync_mode;
		logic cip_start;
		logic hop_ready; // Cipher result already stored in the word
		btn_t code;
		btn_t btn_prev;
		logic [65:0] word;
		logic dout;
		logic oe;
		logic boost;
		logic [11:0] boost_cnt;
		logic [15:0] cfg;
		logic [63:0] key;
		logic [15:0] sync;
		logic [31:0] serial;
		logic [31:0] seed;
		logic [11:0] disc;
		logic arm;
		wb_rsp_t wb;
	} tx_t;

	localparam tx_t TX_RST = '{state: S_IDLE, default: '0};

endpackage

// ===== hw/hop_cipher.sv
// Iterative 32-bit block mixer keyed by a 64-bit key.
// Assumes start is a one-cycle pulse and inputs hold while it is high.
module hop_cipher
	import hop_tx_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [63:0] key_i,
	input wire logic [31:0] plain_i,
	output logic done_o,
	output logic [31:0] cipher_o
);

	cip_t q; // Whole state of the mixer
	cip_t d;
	logic fb; // Feedback bit of one round

	// One round per clock; a start while busy restarts the block
	always_comb begin
		d = q;
		d.done = 1'b0;
		fb = q.data[0] ^ q.data[16] ^ q.key[0]
			^ MIX_TABLE[{q.data[31], q.data[26], q.data[20],
			q.data[9], q.data[1]}];
		if (start_i) begin
			d.busy = 1'b1;
			d.cnt = CIPHER_ROUNDS;
			d.data = plain_i;
			d.key = key_i;
		end else if (q.busy) begin
			d.data = {fb, q.data[31:1]};
			d.key = {q.key[0], q.key[63:1]};
			d.cnt = q.cnt - 10'h001;
			if (q.cnt == 10'h001) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	// Register the state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= CIP_RST;
		end else begin
			q <= d;
		end
	end

	assign done_o = q.done;
	assign cipher_o = q.data;

endmodule // hop_cipher

// ===== hw/hop_tx.sv
// Code word framer of a code hopping transmitter with Wishbone registers.
// Assumes buttons and supply comparators are synchronous to clk_i.
module hop_tx
	import hop_tx_pkg::*;
#(
	parameter int unsigned TE_LONG_CYC = TE_LONG_US * CLK_MHZ,
	parameter int unsigned TE_SHORT_CYC = TE_SHORT_US * CLK_MHZ,
	parameter int unsigned DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ,
	parameter int unsigned MODE_TEST_CYC = MODE_TEST_US * CLK_MHZ,
	parameter int unsigned OE_DELAY_CYC = OE_DELAY_US * CLK_MHZ,
	parameter longint unsigned SHUTOFF_CYC =
		64'(SHUTOFF_MS) * 1000 * CLK_MHZ,
	parameter int unsigned PRE_TE = 23, // Preamble elements
	parameter int unsigned HDR_TE = 10, // Header elements
	parameter int unsigned GUARD_TE = 39 // Guard elements
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire wb_req_t wb_i,
	output wb_rsp_t wb_o,
	input wire btn_t buttons_i,
	input wire supply_t supply_i,
	input wire logic below_boost_ref_i,
	output logic data_o,
	output logic data_oe_o,
	output logic boost_o
);

	// Refuse settings the counters cannot hold
	if (PRE_TE < 1 || PRE_TE > 127 || HDR_TE < 1 || HDR_TE > 127 ||
		GUARD_TE < 1 || GUARD_TE > 127) begin : g_bad_len
		$error("Element counts must lie in 1..127");
	end
	if (SHUTOFF_CYC < 2 || SHUTOFF_CYC > 64'hFFFF_FFFF ||
		TE_LONG_CYC < 64 || TE_SHORT_CYC < 64 || DEBOUNCE_CYC < 1 ||
		MODE_TEST_CYC < 1 || OE_DELAY_CYC < 1) begin : g_bad_time
		$error("Timing parameter out of range");
	end

	tx_t q; // All state of the block
	tx_t d;
	logic cip_done; // Pulse: cipher result valid
	logic [31:0] cip_out;
	logic [31:0] base; // Element length before trim
	logic [31:0] step; // One trim step
	logic [31:0] te_len; // Trimmed element length in cycles
	logic tick; // Current element or wait ends this cycle
	logic any; // Some button pressed
	logic new_press; // A button went active since last cycle
	logic c_fall;
	logic c_rise;
	logic launch; // Build a new code word from the buttons
	logic blank; // Current word is a blanked alternate
	logic keep; // Another word follows the guard
	logic [3:0] func; // Function bits of the word
	logic [33:0] fixed; // Fixed portion
	logic [31:0] hop; // Hopping portion
	logic [31:0] rd; // Read data mux

	// Merge write data into a register under the byte selects
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = val[8*i +: 8];
			end
		end
		return r;
	endfunction

	// Plaintext goes out the cycle after the build starts
	hop_cipher u_cipher (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(q.cip_start),
		.key_i(q.key),
		.plain_i({func, q.disc, q.sync}), // RULE_10 RULE_25
		.done_o(cip_done),
		.cipher_o(cip_out)
	);

	// Function code from the sampled buttons
	always_comb begin
		func = {q.cfg[CFG_FORCE] | q.code.c, q.code}; // RULE_06 RULE_23
		hop = (&q.code) ? q.seed : cip_out; // RULE_19
		// Top nibble carries the function code unless the full serial is on
		fixed = {q.word[BATT_POS], 1'b0,
			q.cfg[CFG_FULL] ? q.serial[31:28] : func, // RULE_07 RULE_11
			q.serial[SER_LOW_BITS-1:0]};
	end

	// Element timing, status reads and the whole transmit sequence
	always_comb begin
		d = q;
		d.cip_start = 1'b0;
		d.wb.ack = 1'b0;
		d.btn_prev = buttons_i;
		base = q.cfg[CFG_RATE] ? TE_SHORT_CYC : TE_LONG_CYC; // RULE_03
		step = base >> TRIM_SHIFT;
		te_len = base + step * 32'(q.cfg[CFG_TRIM_MSB:CFG_TRIM_LSB])
			- step * 32'(TRIM_MID); // RULE_01
		tick = (q.tmr == 32'h0);
		any = |buttons_i;
		new_press = |(buttons_i & ~q.btn_prev);
		c_fall = q.btn_prev.c & ~buttons_i.c;
		c_rise = ~q.btn_prev.c & buttons_i.c;
		launch = 1'b0;
		blank = q.cfg[CFG_RATE] & q.odd; // RULE_03
		keep = 1'b0;
		rd = 32'h0;

		// Bus slave: answer one cycle after the request, once
		if (wb_i.cyc && wb_i.stb && !q.wb.ack) begin
			d.wb.ack = 1'b1;
			unique case (wb_i.adr)
				OFS_CONFIG: rd = {16'h0, q.cfg};
				OFS_KEY_LO: rd = q.key[31:0];
				OFS_KEY_HI: rd = q.key[63:32];
				OFS_SYNC: rd = {16'h0, q.sync};
				OFS_SERIAL: rd = q.serial;
				OFS_SEED: rd = q.seed;
				OFS_DISC: rd = {20'h0, q.disc};
				OFS_CONTROL: rd = {31'h0, q.arm};
				OFS_STATUS: rd = {20'h0, q.state, q.words, q.shut,
					q.word[BATT_POS], q.sync_mode, 1'b0, q.oe};
				default: rd = 32'h0; // Unmapped reads as zero
			endcase
			d.wb.dat = rd;
			if (wb_i.we) begin
				unique case (wb_i.adr)
					OFS_CONFIG: d.cfg = 16'(merge({16'h0, q.cfg},
						wb_i.dat, wb_i.sel));
					OFS_KEY_LO: d.key[31:0] = merge(q.key[31:0],
						wb_i.dat, wb_i.sel);
					OFS_KEY_HI: d.key[63:32] = merge(q.key[63:32],
						wb_i.dat, wb_i.sel);
					OFS_SYNC: d.sync = 16'(merge({16'h0, q.sync},
						wb_i.dat, wb_i.sel));
					OFS_SERIAL: d.serial = merge(q.serial,
						wb_i.dat, wb_i.sel);
					OFS_SEED: d.seed = merge(q.seed, wb_i.dat, wb_i.sel);
					OFS_DISC: d.disc = 12'(merge({20'h0, q.disc},
						wb_i.dat, wb_i.sel));
					OFS_CONTROL: d.arm = wb_i.sel[0] ? wb_i.dat[0] : q.arm;
					default: d.arm = q.arm; // Writes elsewhere ignored
				endcase
			end
		end

		// Continuous hold timer; release clears it
		if (any && q.state != S_IDLE) begin
			d.alive = q.alive + 32'h1;
			if (q.alive == 32'(SHUTOFF_CYC - 1)) begin
				d.shut = 1'b1; // RULE_20
			end
		end else if (!any) begin
			d.alive = 32'h0;
		end

		// Timer runs down once per cycle
		if (!tick) begin
			d.tmr = q.tmr - 32'h1;
		end

		unique case (q.state)
			S_IDLE: begin
				d.sync_mode = 1'b0;
				if (!any) begin
					d.shut = 1'b0;
				end
				if (q.arm && c_fall && (buttons_i.a || buttons_i.b)) begin
					d.code = '{c: 1'b0, b: buttons_i.b,
						a: buttons_i.a}; // RULE_12
					d.sync_mode = 1'b1;
					d.tmr = MODE_TEST_CYC - 1; // RULE_15
					d.state = S_SYNC_TEST;
				end else if (any && !q.shut) begin
					d.tmr = DEBOUNCE_CYC - 1; // RULE_24
					d.words = 3'h0;
					d.odd = 1'b0;
					d.first = 1'b1;
					d.state = S_DEBOUNCE;
				end
			end
			S_DEBOUNCE: begin
				if (tick) begin
					launch = 1'b1; // RULE_24
				end
			end
			S_SYNC_TEST: begin
				if (tick) begin
					launch = 1'b1;
					d.tmr = OE_DELAY_CYC - 1; // RULE_15
				end
			end
			S_CIPHER: begin
				// Wait for the cipher; sync mode also waits the pin delay
				if (cip_done) begin
					d.word[HOP_BITS-1:0] = hop; // RULE_09 RULE_25
					// Held, as the pin delay may outlast the cipher
					d.hop_ready = 1'b1;
				end
				if (cip_done && !q.sync_mode) begin
					d.tmr = te_len - 32'h1;
					d.te_left = 7'(PRE_TE - 1); // RULE_26
					d.state = (q.cfg[CFG_LEAD] && q.first) ?
						S_LEAD : S_PREAMBLE; // RULE_05
				end
			end
			S_LEAD: begin
				if (tick) begin
					d.tmr = te_len - 32'h1;
					d.state = S_PREAMBLE; // RULE_05
				end
			end
			S_PREAMBLE: begin
				if (tick) begin
					d.tmr = te_len - 32'h1;
					d.te_left = q.te_left - 7'h1;
					if (q.te_left == 7'h0) begin
						d.te_left = 7'(HDR_TE - 1); // RULE_26
						d.state = S_HEADER; // RULE_08
					end
				end
			end
			S_HEADER: begin
				if (tick) begin
					d.tmr = te_len - 32'h1;
					d.te_left = q.te_left - 7'h1;
					if (q.te_left == 7'h0) begin
						d.bit_idx = 7'h0;
						d.phase = 2'h0;
						d.state = S_DATA; // RULE_08
					end
				end
			end
			S_DATA: begin
				if (tick) begin
					d.tmr = te_len - 32'h1;
					d.phase = q.phase + 2'h1; // RULE_27
					if (q.phase == 2'h2) begin
						d.phase = 2'h0;
						d.bit_idx = q.bit_idx + 7'h1;
						if (q.bit_idx == 7'(WORD_BITS - 1)) begin
							d.te_left = 7'(GUARD_TE - 1); // RULE_26
							d.state = S_GUARD; // RULE_08
						end
					end
				end
			end
			S_GUARD: begin
				if (tick) begin
					d.tmr = te_len - 32'h1;
					d.te_left = q.te_left - 7'h1;
					if (q.te_left == 7'h0) begin
						// Blanked words do not count toward the minimum
						if (!blank && q.words != 3'(MIN_WORDS)) begin
							d.words = q.words + 3'h1; // RULE_04
						end
						d.odd = ~q.odd; // RULE_03
						d.first = 1'b0;
						keep = (any && !q.shut) || // RULE_17
							(q.cfg[CFG_MIN] &&
							d.words < 3'(MIN_WORDS)); // RULE_04
						d.word[REPEAT_POS] = 1'b1;
						d.te_left = 7'(PRE_TE - 1);
						d.state = keep ? S_PREAMBLE : S_IDLE; // RULE_16
					end
				end
			end
			S_SYNC_SHIFT: begin
				// Each rising edge of the outside clock moves one bit
				if (c_rise) begin
					d.bit_idx = q.bit_idx + 7'h1;
					if (q.bit_idx == 7'(SYNC_BITS - 1)) begin
						d.state = S_IDLE; // RULE_14
					end
				end
			end
			default: d.state = S_IDLE; // Unused codes recover
		endcase

		// A fresh button aborts the word and rebuilds the code
		if (new_press && !q.shut && !q.sync_mode && (q.state == S_LEAD ||
			q.state == S_PREAMBLE || q.state == S_HEADER ||
			q.state == S_DATA || q.state == S_GUARD)) begin
			launch = 1'b1; // RULE_18
		end

		// Timeout ends any self-timed transmission at once
		if (d.shut && !q.sync_mode && q.state != S_IDLE) begin
			launch = 1'b0;
			d.state = S_IDLE; // RULE_20
		end

		// Sample buttons, supply level and bump the counter
		if (launch) begin
			if (!q.sync_mode) begin
				d.code = buttons_i;
			end
			d.cip_start = 1'b1; // RULE_25
			d.hop_ready = 1'b0; // Old result must not release sync mode
			d.sync = q.sync + 16'h1;
			d.word = '0;
			d.word[BATT_POS] = !q.cfg[CFG_LEVEL] ? supply_i.below_lo :
				(q.cfg[CFG_FORCE] ? supply_i.below_mid :
				supply_i.below_hi); // RULE_02 RULE_22
			d.state = S_CIPHER;
		end

		// Fixed part follows the hopping part, written every cipher-wait cycle after the start pulse
		if (q.state == S_CIPHER && !q.cip_start) begin
			d.word[WORD_BITS-1:HOP_BITS] = fixed; // RULE_09 RULE_11
		end

		// Sync mode leaves the cipher wait after the pin delay
		if (q.state == S_CIPHER && q.sync_mode && !launch) begin
			if (tick && !q.cip_start && (cip_done || q.hop_ready)) begin
				d.bit_idx = 7'h0;
				d.state = S_SYNC_SHIFT; // RULE_15
			end
		end

		// Pin level from the next state
		d.oe = (d.state == S_LEAD || d.state == S_PREAMBLE ||
			d.state == S_HEADER || d.state == S_DATA ||
			d.state == S_GUARD || d.state == S_SYNC_SHIFT); // RULE_15
		unique case (d.state)
			S_LEAD: d.dout = 1'b1; // RULE_05
			S_PREAMBLE: d.dout = ~d.te_left[0] & ~blank;
			S_DATA: d.dout = ~blank & ((d.phase == 2'h0) ||
				(d.phase == 2'h1 && !d.word[d.bit_idx])); // RULE_27
			S_SYNC_SHIFT: d.dout = (d.bit_idx < 7'(WORD_BITS)) ?
				d.word[d.bit_idx] : 1'b0; // RULE_14
			default: d.dout = 1'b0;
		endcase

		// Step-up drive only while transmitting on a low supply
		if (d.oe && below_boost_ref_i) begin
			d.boost_cnt = q.boost_cnt + 12'h1;
			if (q.boost_cnt == 12'(BOOST_HALF_CYC - 1)) begin
				d.boost_cnt = 12'h0;
				d.boost = ~q.boost; // RULE_21
			end
		end else begin
			d.boost_cnt = 12'h0;
			d.boost = 1'b0; // RULE_21
		end
	end

	// Register the whole state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= TX_RST;
		end else begin
			q <= d;
		end
	end

	assign wb_o = q.wb;
	assign data_o = q.dout;
	assign data_oe_o = q.oe;
	assign boost_o = q.boost;

endmodule // hop_tx

// ===== sim/hop_tx_assertions.sv
// Port checker for the code word framer, attached by bind.
// Assumes one clock, synchronous reset and a single Wishbone master.
module hop_tx_assertions
	import hop_tx_pkg::*;
#(
	parameter int unsigned TE_SHORT_CYC = 64
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire wb_req_t wb_i,
	input wire wb_rsp_t wb_o,
	input wire btn_t buttons_i,
	input wire supply_t supply_i,
	input wire logic below_boost_ref_i,
	input wire logic data_o,
	input wire logic data_oe_o,
	input wire logic boost_o
);
	// Shortest word body: 66 bits of three short elements at lowest trim
	localparam int unsigned WORD_MIN =
		198 * (TE_SHORT_CYC - TRIM_MID * (TE_SHORT_CYC >> TRIM_SHIFT));
	logic [31:0] run_q; // Cycles the data pin has been driven so far
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Drive run length, cleared on release so aborts show up short
	always_ff @(posedge clk_i) begin
		if (rst_i || !data_oe_o) begin
			run_q <= '0;
		end else begin
			run_q <= run_q + 32'h1;
		end
	end
	// A request the slave has not yet answered
	sequence s_taken;
		wb_i.cyc && wb_i.stb && !wb_o.ack;
	endsequence
	// Button closure seen while the pin is idle
	sequence s_press;
		!data_oe_o && buttons_i == '0 ##1 buttons_i != '0;
	endsequence
	a_ack_next: assert property (s_taken |=> wb_o.ack)
		else $error("ack missing one cycle after a request");
	a_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("ack held longer than one cycle");
	a_ack_unasked: assert property (!(wb_i.cyc && wb_i.stb) |=> !wb_o.ack)
		else $error("ack without a request");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst_i |=> !data_oe_o && !boost_o && !wb_o.ack)
		else $error("outputs active after reset");
	a_debounce_wait: assert property (s_press |-> (!data_oe_o)[*8])
		else $error("data pin driven before debounce");
	a_boost_idle: assert property ((!data_oe_o)[*2] |-> !boost_o)
		else $error("boost pulsing while not sending");
	a_pin_quiet: assert property (!data_oe_o |-> !data_o)
		else $error("data high while pin released");
	// Aborts and timeouts end early, but only with a button still held
	a_word_whole: assert property ($fell(data_oe_o) && buttons_i == '0
		|-> run_q >= WORD_MIN)
		else $error("transmission ended before a whole word");
endmodule // hop_tx_assertions

bind hop_tx hop_tx_assertions #(.TE_SHORT_CYC(TE_SHORT_CYC)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
	.buttons_i(buttons_i), .supply_i(supply_i),
	.below_boost_ref_i(below_boost_ref_i), .data_o(data_o),
	.data_oe_o(data_oe_o), .boost_o(boost_o)
);

// ===== sim/hop_rx_model.sv
// Receiver side of the RF stage: decodes PWM words from the data pin.
// Assumes the element length is given by the bench and trim is nominal.
module hop_rx_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic data_i,
	input wire logic oe_i,
	input wire logic [15:0] te_i,
	output logic [65:0] word_o,
	output logic [15:0] pre_hi_o,
	output logic [7:0] n_words_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int hi; // Length of the current high pulse
	int lo; // Length of the current low run
	int pulses; // Pulses seen in this frame
	int pre; // High time of the two leading pulses
	logic [65:0] shr; // Bits gathered so far, first bit at 0
	// Pulse-width decoder; a low run of 3.5 elements opens a new frame
	always @(posedge clk_i) begin
		if (rst_i) begin
			word_o <= '0;
			pre_hi_o <= '0;
			n_words_o <= '0;
		end
		if (rst_i || !oe_i) begin
			hi <= 0;
			lo <= 0;
			pulses <= 0;
			pre <= 0;
		end else if (data_i) begin
			hi <= hi + 1;
			lo <= 0;
		end else begin
			lo <= lo + 1;
			if (2 * lo == 7 * te_i) begin
				pulses <= 0;
				pre <= 0;
			end
			if (hi != 0) begin
				hi <= 0;
				pulses <= pulses + 1;
				// Lead and preamble merge into the first two pulses
				if (pulses < 2) begin
					pre <= pre + hi;
					pre_hi_o <= 16'(pre + hi);
				end else begin
					shr[pulses - 2] <= (2 * hi < 3 * te_i);
					if (pulses == 67) begin
						word_o <= {2 * hi < 3 * te_i, shr[64:0]};
						n_words_o <= n_words_o + 8'h01;
					end
				end
			end
		end
	end
endmodule // hop_rx_model

// ===== sim/test_hop_tx.sv
// Self-checking bench: registers over Wishbone, words decoded by the model.
// Assumes shortened timing parameters so three words fit in the run.
module test_hop_tx
	import hop_tx_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] SER = 32'hB7E1_5163; // Serial number
	localparam logic [31:0] SEED = 32'h3C96_E1A5; // Seed word
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	wb_req_t wb_i = '0;
	wb_rsp_t wb_o;
	btn_t buttons_i = '0;
	supply_t supply_i = '0;
	logic below_boost_ref_i = 1'b0;
	logic data_o;
	logic data_oe_o;
	logic boost_o;
	logic [65:0] rx_word;
	logic [15:0] rx_pre;
	logic [7:0] rx_n;
	logic [15:0] te_cyc = 16'h0040; // Element length told to the model
	logic [31:0] rd;
	int n_fail = 0;
	int n_checks = 0;
	int cycles = 0;
	int n_boost = 0;
	int nb;

	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;

	// Guard, sync entry and shutoff keep their full lengths
	hop_tx #(.TE_LONG_CYC(128), .TE_SHORT_CYC(64), .DEBOUNCE_CYC(20),
		.PRE_TE(3), .HDR_TE(2)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o),
		.buttons_i(buttons_i), .supply_i(supply_i),
		.below_boost_ref_i(below_boost_ref_i), .data_o(data_o),
		.data_oe_o(data_oe_o), .boost_o(boost_o));

	hop_rx_model rf (.clk_i(clk_i), .rst_i(rst_i), .data_i(data_o),
		.oe_i(data_oe_o), .te_i(te_cyc), .word_o(rx_word),
		.pre_hi_o(rx_pre), .n_words_o(rx_n));

	// Count boost pulses
	always @(posedge boost_o) n_boost++;

	// Hang guard: three words need about 64000 cycles
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 90000) begin
			n_fail++;
			give_verdict();
		end
	end

	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task check(input string what, input logic [65:0] exp,
		input logic [65:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Classic single cycle; waits for ack, releases right after it
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] dat, output logic [31:0] q);
		int n;
		n = 0;
		wb_i <= wb_req_t'{cyc: 1'b1, stb: 1'b1, we: we, adr: adr,
			sel: 4'hF, dat: dat};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_o.ack !== 1'b1 && n < 50);
		if (n == 50)
			n_fail++;
		q = wb_o.dat;
		wb_i <= '0;
		@(posedge clk_i);
	endtask

	// Bounded wait for the pin enable to reach a level
	task automatic wait_oe(input logic lvl, input int limit);
		int n;
		n = 0;
		while (data_oe_o !== lvl && n < limit) begin
			@(posedge clk_i);
			n++;
		end
		if (n == limit)
			n_fail++;
	endtask

	// One activation, buttons released as soon as sending starts
	task automatic send(input logic [15:0] cfg, input btn_t b,
		input supply_t s, input logic [15:0] te);
		wb(1'b1, OFS_CONFIG, {16'h0000, cfg}, rd);
		te_cyc <= te;
		supply_i <= s;
		buttons_i <= b;
		wait_oe(1'b1, 2000);
		buttons_i <= '0;
		wait_oe(1'b0, 40000);
		repeat (4) @(posedge clk_i);
	endtask

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, OFS_CONFIG, '0, rd);
		check("config reset", '0, {34'h0, rd});
		wb(1'b1, OFS_SERIAL, SER, rd);
		wb(1'b1, OFS_SEED, SEED, rd);
		wb(1'b0, OFS_SERIAL, '0, rd);
		check("serial", {34'h0, SER}, {34'h0, rd});
		wb(1'b0, 8'h40, '0, rd);
		check("unmapped", '0, {34'h0, rd});
		// Short rate, button a, supply between the trip levels
		below_boost_ref_i <= 1'b1;
		send(16'h0028, 3'b001, 3'b110, 16'h0040);
		check("fixed A", {34'h0, 4'h1, SER[27:0]}, {34'h0, rx_word[63:32]});
		check("battery A", '0, {65'h0, rx_word[65]});
		check("lead A", {50'h0, 16'h0080}, {50'h0, rx_pre});
		check("words A", {58'h0, 8'h01}, {58'h0, rx_n});
		check("boost A", {65'h0, 1'b1}, {65'h0, n_boost != 0});
		// All three buttons, full serial, 6.75 trip
		below_boost_ref_i <= 1'b0;
		nb = n_boost;
		send(16'h0338, 3'b111, 3'b110, 16'h0040);
		check("seed B", {34'h0, SEED}, {34'h0, rx_word[31:0]});
		check("fixed B", {34'h0, SER}, {34'h0, rx_word[63:32]});
		check("battery B", {65'h0, 1'b1}, {65'h0, rx_word[65]});
		check("words B", {58'h0, 8'h02}, {58'h0, rx_n});
		check("boost B", {65'h0, 1'b1}, {65'h0, n_boost == nb});
		// Long rate, lead pulse, forced fourth bit, button b
		send(16'h0198, 3'b010, 3'b100, 16'h0080);
		check("fixed C", {34'h0, 4'hA, SER[27:0]}, {34'h0, rx_word[63:32]});
		check("battery C", '0, {65'h0, rx_word[65]});
		check("lead C", {50'h0, 16'h0180}, {50'h0, rx_pre});
		check("words C", {58'h0, 8'h03}, {58'h0, rx_n});
		give_verdict();
	end
endmodule // test_hop_tx
